//--- scg_top.sv
// Purpose: Configuration and control of the system clock generator
// Assumes: APB slave at 250 MHz, pins synchronised here
// Notes: Analog loop parts are driven by the registered control outputs
//
// Function
// - Multiplier path is on while power-down bit is 0 (reset), off at 1.
// - With the multiplier off, the buffered timebase is the sampling clock.
// - A low clock source mode pin keeps the crystal maintaining amplifier on.
// - A high mode pin turns the amplifier off, multiplier enable untouched.
// - The edge doubler pulses once per rising and per falling timebase edge.
// - The phase detector takes falling edges only, of the direct or the doubled timebase.
// - Feedback is fixed divide-by-2 then divide-by-N, N 2..33, ratio 4..66 even.
// - The divider code is 5 bits, 0..31, and N is the code plus two.
// - A setting picks one of three pump currents: 125, 250 or 375 uA.
// - A setting picks high or low VCO gain range.
// - After reset the overall multiplier ratio is 40.
`timescale 1ns/100ps
`default_nettype none
module scg_top
    import scg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SCG_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_source_mode_pin,
    input wire logic tb_in,
    input wire logic vco_in,
    output logic pll_en,
    output logic bypass_sel,
    output logic maint_amp_en,
    output logic [1:0] cp_sel,
    output logic vco_gain_hi,
    output logic [5:0] fb_n,
    output logic pfd_up,
    output logic pfd_dn
);
    scg_cfg_t cfg_q, cfg_d;
    scg_pfd_t pfd_q, pfd_d;
    scg_pfd_st_t st_q, st_d;
    logic mode_s1_q, mode_s2_q;
    logic ref_evt, fb_evt;
    logic acc, wr_fire, wr_ctrl, wr_ndiv, hit;
    logic [31:0] rd_word, stat_word;
    logic [1:0] cp_next;
    logic [5:0] n_mod;

    // Address decode shared by read mux, error answer and write strobes
    function automatic logic is_reg(input logic [SCG_AW-1:0] a,
                                    input logic [SCG_AW-1:0] ofs);
        return a == ofs;
    endfunction

    // APB: access phase is answered one cycle after it starts
    assign acc = psel & penable & ~pready;
    assign hit = is_reg(paddr, SCG_CTRL_OFS) | is_reg(paddr, SCG_NDIV_OFS)
               | is_reg(paddr, SCG_STAT_OFS);
    // Writes land only on the edge where the master sees pready
    assign wr_fire = psel & penable & pready & pwrite;
    assign wr_ctrl = wr_fire & is_reg(paddr, SCG_CTRL_OFS);
    assign wr_ndiv = wr_fire & is_reg(paddr, SCG_NDIV_OFS);

    // Status word shows live state, not just stored settings
    assign stat_word = {14'h0000, pfd_q.up, pfd_q.dn, 2'h0, fb_n,
                        5'h00, mode_s2_q, maint_amp_en, pll_en};

    assign rd_word =
        is_reg(paddr, SCG_CTRL_OFS) ?
            {26'h0000000, cfg_q.cp_sel, 1'b0, cfg_q.vco_hi,
             cfg_q.dbl_sel, cfg_q.pd} :
        is_reg(paddr, SCG_NDIV_OFS) ? {27'h0000000, cfg_q.n_code} :
        is_reg(paddr, SCG_STAT_OFS) ? stat_word : 32'h00000000;

    // Reserved charge pump code is refused; the old current is kept
    assign cp_next = (pwdata[SCG_CP_LSB +: 2] == SCG_CP_BAD) ?
                     cfg_q.cp_sel : pwdata[SCG_CP_LSB +: 2];

    // Next configuration from the two writable registers
    always_comb begin
        cfg_d = cfg_q;
        if (wr_ctrl) begin
            cfg_d.pd = pwdata[SCG_PD_BIT];
            cfg_d.dbl_sel = pwdata[SCG_DBL_BIT];
            cfg_d.vco_hi = pwdata[SCG_VCO_BIT];
            cfg_d.cp_sel = cp_next;
        end
        if (wr_ndiv)
            cfg_d.n_code = pwdata[SCG_N_LSB +: 5];
    end

    // Bus answer flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc & ~hit;
            if (acc)
                prdata <= pwrite ? 32'h00000000 : rd_word;
        end
    end

    // Configuration register; reset gives ratio 2*(18+2) = 40
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_q <= '{pd: SCG_PD_RST, dbl_sel: SCG_DBL_RST,
                       vco_hi: SCG_VCO_RST, cp_sel: SCG_CP_RST,
                       n_code: SCG_N_RST};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Mode pin is asynchronous; only the second flop is read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            mode_s1_q <= clock_source_mode_pin;
            mode_s2_q <= mode_s1_q;
        end
    end

    // N modulus: code plus bias, 2..33
    assign n_mod = 6'({1'b0, cfg_q.n_code} + SCG_N_BIAS);

    // Analog control outputs, all from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pll_en <= 1'b0;
            bypass_sel <= 1'b1;
            maint_amp_en <= 1'b1;
            cp_sel <= SCG_CP_RST;
            vco_gain_hi <= SCG_VCO_RST;
            fb_n <= 6'(SCG_N_RST + SCG_N_BIAS);
        end else begin
            pll_en <= ~cfg_q.pd;
            bypass_sel <= cfg_q.pd;
            maint_amp_en <= ~mode_s2_q;
            cp_sel <= cfg_q.cp_sel;
            vco_gain_hi <= cfg_q.vco_hi;
            fb_n <= n_mod;
        end
    end

    // Reference path: synchroniser, optional doubler, falling edges
    scg_edge_dbl u_ref (
        .clk(clk),
        .rst_b(rst_b),
        .tb_in(tb_in),
        .dbl_sel(cfg_q.dbl_sel),
        .ref_evt(ref_evt)
    );

    // Feedback path, held idle while the multiplier is powered down
    scg_fb_div #(.NW(6)) u_fb (
        .clk(clk),
        .rst_b(rst_b),
        .run(pll_en),
        .vco_in(vco_in),
        .n_mod(fb_n),
        .fb_evt(fb_evt)
    );

    // Tri-state detector: lead of one edge over the other steers the pump.
    // Simultaneous edges cancel, which avoids a dead zone glitch pair.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SCG_PFD_IDLE: begin
                if (ref_evt && !fb_evt)
                    st_d = SCG_PFD_UP;
                else if (fb_evt && !ref_evt)
                    st_d = SCG_PFD_DN;
            end
            SCG_PFD_UP: begin
                if (fb_evt && !ref_evt)
                    st_d = SCG_PFD_IDLE;
            end
            SCG_PFD_DN: begin
                if (ref_evt && !fb_evt)
                    st_d = SCG_PFD_IDLE;
            end
            default: st_d = SCG_PFD_IDLE;
        endcase
        if (!pll_en)
            st_d = SCG_PFD_IDLE;
    end

    assign pfd_d.up = (st_d == SCG_PFD_UP);
    assign pfd_d.dn = (st_d == SCG_PFD_DN);

    // Detector state and steering outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= SCG_PFD_IDLE;
            pfd_q <= '0;
            pfd_up <= 1'b0;
            pfd_dn <= 1'b0;
        end else begin
            st_q <= st_d;
            pfd_q <= pfd_d;
            pfd_up <= pfd_d.up;
            pfd_dn <= pfd_d.dn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // A control write lands on the edge where the master sees pready
    sequence ctrl_write_s;
        wr_ctrl;
    endsequence

    // One answer pulse, then the slave is quiet again
    sequence bus_answer_s;
        pready ##1 !pready;
    endsequence

    // Enable follows the power-down bit two edges after the write lands
    pll_follow_a: assert property (
        ctrl_write_s |=> ##1 pll_en == !$past(pwdata[SCG_PD_BIT], 2))
        else $error("multiplier enable does not follow power-down bit");

    // A powered-down loop must not steer the pump
    pfd_idle_a: assert property (
        !pll_en |=> !pfd_up && !pfd_dn)
        else $error("pump steered while multiplier is off");

    // Bypass and multiplier path are never selected together
    bypass_tie_a: assert property (
        bypass_sel == !pll_en)
        else $error("bypass and multiplier enabled together");

    // Crystal mode brings the maintaining amplifier back
    amp_xtal_a: assert property (
        $fell(mode_s2_q) |=> maint_amp_en)
        else $error("amplifier left off in crystal mode");

    // External mode turns the amplifier off
    amp_mode_a: assert property (
        $rose(mode_s2_q) |=> !maint_amp_en)
        else $error("amplifier left on in external mode");

    // The mode pin alone never moves the multiplier enable
    mode_keep_a: assert property (
        $changed(mode_s2_q) && !wr_ctrl && !$past(wr_ctrl) |=>
            $stable(pll_en))
        else $error("mode pin changed the multiplier enable");

    // Overall ratio stays even and inside its legal span
    fb_range_a: assert property (
        {fb_n, 1'b0} inside {[7'd4:7'd66]})
        else $error("feedback ratio out of range");

    // Modulus is the written code plus the bias
    n_bias_a: assert property (
        wr_ndiv |=> ##1
            fb_n == 6'({1'b0, $past(pwdata[4:0], 2)} + SCG_N_BIAS))
        else $error("modulus is not code plus two");

    // A reserved pump code leaves the old current in place
    cp_keep_a: assert property (
        wr_ctrl && pwdata[SCG_CP_LSB +: 2] == SCG_CP_BAD |=> ##1
            cp_sel == $past(cfg_q.cp_sel, 2))
        else $error("reserved pump code accepted");

    // Only the three legal pump currents ever reach the output
    cp_legal_a: assert property (
        cp_sel != SCG_CP_BAD)
        else $error("reserved pump current driven");

    // VCO range follows its control bit
    vco_gain_a: assert property (
        ctrl_write_s |=> ##1 vco_gain_hi == $past(pwdata[SCG_VCO_BIT], 2))
        else $error("VCO gain not applied");

    // Reset leaves a ratio of forty
    def_ratio_a: assert property (
        !$past(rst_b) |-> {fb_n, 1'b0} == SCG_DEF_RATIO)
        else $error("ratio after reset is not forty");

    // Direct input after reset, then whatever software picks
    def_dbl_a: assert property (
        !$past(rst_b) |-> !cfg_q.dbl_sel)
        else $error("doubler selected after reset");
    dbl_follow_a: assert property (
        ctrl_write_s |=> cfg_q.dbl_sel == $past(pwdata[SCG_DBL_BIT]))
        else $error("doubler select not applied");

    // Tri-state detector never drives both pump directions
    pfd_excl_a: assert property (
        !(pfd_up && pfd_dn))
        else $error("pump up and down at once");

    // Every access gets exactly one answer cycle
    ready_one_a: assert property (
        acc |=> bus_answer_s)
        else $error("APB answer not one cycle");

    // Unmapped addresses are answered with an error
    err_map_a: assert property (
        acc && !hit |=> pslverr)
        else $error("unmapped access not flagged");
endmodule // scg_top
`default_nettype wire

//--- scg_pkg.sv
// Purpose: Shared constants and types for the system clock generator config
// Assumes: 32-bit APB register access, one 250 MHz clock
// Notes: Offsets are byte addresses; each register takes one aligned word
`default_nettype none
package scg_pkg;

    // Register byte offsets
    localparam int unsigned SCG_AW = 12;
    localparam logic [11:0] SCG_CTRL_OFS = 12'h000;
    localparam logic [11:0] SCG_NDIV_OFS = 12'h004;
    localparam logic [11:0] SCG_STAT_OFS = 12'h008;

    // Field positions in the control and divider words
    localparam int unsigned SCG_PD_BIT = 0;
    localparam int unsigned SCG_DBL_BIT = 1;
    localparam int unsigned SCG_VCO_BIT = 2;
    localparam int unsigned SCG_CP_LSB = 4;
    localparam int unsigned SCG_N_LSB = 0;

    // Values after reset
    localparam logic SCG_PD_RST = 1'b0;
    localparam logic SCG_DBL_RST = 1'b0;
    localparam logic SCG_VCO_RST = 1'b0;
    localparam logic [1:0] SCG_CP_RST = 2'h1;
    localparam logic [4:0] SCG_N_RST = 5'h12;

    // Divider figures: N is the code plus a bias, behind a fixed /2
    localparam logic [5:0] SCG_N_BIAS = 6'h02;
    localparam logic [6:0] SCG_DEF_RATIO = 7'h28;
    localparam logic [1:0] SCG_CP_BAD = 2'h3;

    // Control settings carried as one bundle
    typedef struct packed {
        logic pd;
        logic dbl_sel;
        logic vco_hi;
        logic [1:0] cp_sel;
        logic [4:0] n_code;
    } scg_cfg_t;

    // Phase detector steering pair
    typedef struct packed {
        logic up;
        logic dn;
    } scg_pfd_t;

    typedef enum logic [1:0] {
        SCG_PFD_IDLE,
        SCG_PFD_UP,
        SCG_PFD_DN
    } scg_pfd_st_t;

endpackage
`default_nettype wire

//--- scg_edge_dbl.sv
// Purpose: Timebase synchroniser, edge doubler and falling-edge reference
// Assumes: tb_in is asynchronous and far slower than clk
// Notes: ref_evt is a one-cycle pulse per falling edge of the chosen signal
`timescale 1ns/100ps
`default_nettype none
module scg_edge_dbl
    import scg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tb_in,
    input wire logic dbl_sel,
    output logic ref_evt
);
    logic s1_q, s2_q, s3_q, dbl_q, dbl_d1_q;
    logic fall_direct, fall_dbl;

    // Two-stage synchroniser, then a history flop for edge detection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dbl_q <= 1'b0;
            dbl_d1_q <= 1'b0;
            ref_evt <= 1'b0;
        end else begin
            s1_q <= tb_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dbl_q <= s2_q ^ s3_q;
            dbl_d1_q <= dbl_q;
            ref_evt <= dbl_sel ? fall_dbl : fall_direct;
        end
    end

    // Only falling transitions reach the detector
    assign fall_direct = s3_q & ~s2_q;
    assign fall_dbl = dbl_d1_q & ~dbl_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence tb_edge_s;
        dbl_sel && (s2_q != s3_q);
    endsequence

    dbl_pulse_a: assert property (
        tb_edge_s ##1 dbl_sel [*2] |-> ##1 ref_evt)
        else $error("doubler lost a timebase edge");
    direct_fall_a: assert property (!dbl_sel && $fell(s2_q) |=> ref_evt)
        else $error("direct falling edge not passed on");
endmodule // scg_edge_dbl
`default_nettype wire

//--- scg_fb_div.sv
// Purpose: Feedback divider, fixed divide-by-2 then programmable divide-by-N
// Assumes: vco_in is asynchronous; N is held stable while running
// Notes: fb_evt is a one-cycle pulse every 2*N rising VCO edges
`timescale 1ns/100ps
`default_nettype none
module scg_fb_div
    import scg_pkg::*;
#(
    parameter int unsigned NW = 6
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic vco_in,
    input wire logic [NW-1:0] n_mod,
    output logic fb_evt
);
    logic v1_q, v2_q, v3_q, pre_q;
    logic [NW-1:0] cnt_q;
    logic vco_rise, pre_tick, wrap;

    assign vco_rise = v2_q & ~v3_q;
    assign pre_tick = vco_rise & pre_q; // Fixed prescaler output
    assign wrap = pre_tick && (cnt_q == NW'(n_mod - 1'b1));

    // Counter held clear while the loop is off so it restarts aligned
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            v3_q <= 1'b0;
            pre_q <= 1'b0;
            cnt_q <= '0;
            fb_evt <= 1'b0;
        end else begin
            v1_q <= vco_in;
            v2_q <= v1_q;
            v3_q <= v2_q;
            if (!run) begin
                pre_q <= 1'b0;
                cnt_q <= '0;
                fb_evt <= 1'b0;
            end else begin
                pre_q <= pre_q ^ vco_rise;
                fb_evt <= wrap;
                if (wrap)
                    cnt_q <= '0;
                else if (pre_tick)
                    cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    div_wrap_a: assert property (
        fb_evt |-> $past(cnt_q) == NW'(n_mod - 1'b1))
        else $error("feedback pulse at wrong count");
    div_range_a: assert property (run |-> cnt_q < n_mod)
        else $error("divider count beyond modulus");
endmodule // scg_fb_div
`default_nettype wire

//--- scg_tb_src.sv
// Purpose: Timebase source model driving the timebase input pin
// Assumes: Half period is counted in 4 ns clock periods
// Notes: Holds a fixed level when stopped, like a gated oscillator
`timescale 1ns/100ps
`default_nettype none
module scg_tb_src (
    input wire logic run,
    input wire logic lvl,
    input wire logic [7:0] half,
    output logic tb_in
);
    // Slow square wave keeps the detector input well inside its limit
    initial begin
        tb_in = 1'b0;
        forever begin
            if (run) begin
                #(half * 4) tb_in = ~tb_in;
            end else begin
                #4 tb_in = lvl;
            end
        end
    end
endmodule // scg_tb_src
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the clock generator configuration
// Assumes: APB slave answers in its own time; pins synchronised inside
// Notes: Integer register model gives the expected settings; detector checks use fixed values
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import scg_pkg::*;
;
    logic clk, rst_b, psel, penable, pwrite, mode_pin, vco_in;
    logic [SCG_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, lfsr_q;
    logic pready, pslverr, pll_en, bypass_sel, maint_amp_en, vco_gain_hi;
    logic pfd_up, pfd_dn, tb_in, src_run, src_lvl;
    logic [1:0] cp_sel;
    logic [5:0] fb_n;
    logic [7:0] src_half;
    int miscompares, num_checks, m_pd, m_dbl, m_vco, m_cp, m_code;

    // Design and timebase source
    scg_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .clock_source_mode_pin(mode_pin), .tb_in(tb_in), .vco_in(vco_in),
        .pll_en(pll_en), .bypass_sel(bypass_sel),
        .maint_amp_en(maint_amp_en), .cp_sel(cp_sel),
        .vco_gain_hi(vco_gain_hi), .fb_n(fb_n), .pfd_up(pfd_up),
        .pfd_dn(pfd_dn));
    scg_tb_src src (.run(src_run), .lvl(src_lvl), .half(src_half),
        .tb_in(tb_in));

    // Clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] stat_exp();
        return 32'((m_pd == 0) + (mode_pin ? 4 : 2) + (m_code + 2) * 256);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; a spare edge first keeps psel single-driven
    task automatic apb(input logic w, input logic [SCG_AW-1:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Whole cycles until pready is seen at a rising edge; only the
        // watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [SCG_AW-1:0] a, input logic [31:0] e,
            input logic ee);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk("prdata", e, rd);
        chk("pslverr", 32'(ee), 32'(er));
    endtask

    task automatic wr(input logic [SCG_AW-1:0] a, input logic [31:0] d,
            input logic ee);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk("wr pslverr", 32'(ee), 32'(er));
    endtask

    task automatic chk_cfg();
        chk("pll_en", 32'(m_pd == 0), 32'(pll_en));
        chk("bypass_sel", 32'(m_pd), 32'(bypass_sel));
        chk("maint_amp_en", 32'(!mode_pin), 32'(maint_amp_en));
        chk("cp_sel", 32'(m_cp), 32'(cp_sel));
        chk("vco_gain_hi", 32'(m_vco), 32'(vco_gain_hi));
        chk("fb_n", 32'(m_code + 2), 32'(fb_n));
    endtask

    task automatic set_ctrl(input int pd, input int dbl, input int vco,
            input int cp);
        m_pd = pd;
        m_dbl = dbl;
        m_vco = vco;
        if (cp != 3) m_cp = cp;
        wr(SCG_CTRL_OFS, 32'(pd + dbl * 2 + vco * 4 + cp * 16), 1'b0);
        tick(3);
        chk_cfg();
        rd_chk(SCG_CTRL_OFS, 32'(m_pd + m_dbl * 2 + m_vco * 4 + m_cp * 16), 0);
    endtask

    // Power-down pulse empties divider and detector before each probe
    task automatic restart(input int dbl);
        set_ctrl(1, dbl, 0, 1);
        set_ctrl(0, dbl, 0, 1);
    endtask

    task automatic tb_edge(input logic l);
        src_lvl <= l;
        tick(10);
    endtask

    task automatic vco_pulse(input int k);
        repeat (k) begin
            vco_in <= 1'b1;
            tick(4);
            vco_in <= 1'b0;
            tick(4);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        logic [31:0] d;
        {rst_b, psel, penable, pwrite, mode_pin, vco_in} = 6'h0;
        {paddr, pwdata, src_run, src_lvl} = '0;
        src_half = 8'h19;
        lfsr_q = 32'he5ff;
        {m_pd, m_dbl, m_vco} = {32'd0, 32'd0, 32'd0};
        {m_cp, m_code} = {32'd1, 32'd18};
        tick(2);
        rst_b <= 1'b1;
        tick(4);
        chk_cfg();
        chk("ratio", 32'd40, 32'(fb_n) * 2);
        rd_chk(SCG_CTRL_OFS, 32'h10, 0);
        rd_chk(SCG_STAT_OFS, stat_exp(), 0);
        wr(12'h00c, 32'hffffffff, 1'b1);
        rd_chk(12'h00c, 32'h0, 1);
        rd_chk(SCG_CTRL_OFS, 32'h10, 0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr(lfsr_q);
            d = lfsr_q;
            if (i == 0) d[4:0] = 5'h00;
            if (i == 1) d[4:0] = 5'h1f;
            m_code = int'(d[4:0]);
            wr(SCG_NDIV_OFS, d, 1'b0);
            tick(3);
            chk_cfg();
            rd_chk(SCG_NDIV_OFS, 32'(m_code), 0);
        end
        $display("test divider code done");
        for (int cp = 0; cp < 4; cp++) set_ctrl(0, 0, cp % 2, cp);
        set_ctrl(0, 0, 0, 1);
        $display("test pump and gain done");
        mode_pin <= 1'b1;
        tick(6);
        chk_cfg();
        rd_chk(SCG_STAT_OFS, stat_exp(), 0);
        mode_pin <= 1'b0;
        tick(6);
        chk_cfg();
        $display("test mode pin done");
        set_ctrl(1, 0, 0, 1);
        src_run <= 1'b1;
        tick(300);
        src_run <= 1'b0;
        src_lvl <= 1'b0;
        tick(60);
        chk("idle up", 32'h0, 32'(pfd_up));
        chk("idle dn", 32'h0, 32'(pfd_dn));
        $display("test bypass done");
        restart(0);
        tb_edge(1'b1);
        chk("rise direct", 32'h0, 32'(pfd_up));
        tb_edge(1'b0);
        chk("fall direct", 32'h1, 32'(pfd_up));
        restart(1);
        tb_edge(1'b1);
        chk("rise doubled", 32'h1, 32'(pfd_up));
        restart(1);
        tb_edge(1'b0);
        chk("fall doubled", 32'h1, 32'(pfd_up));
        $display("test detector done");
        for (int c = 0; c < 4; c += 3) begin
            m_code = c;
            wr(SCG_NDIV_OFS, 32'(c), 1'b0);
            restart(0);
            vco_pulse(2 * (c + 2) - 1);
            chk("fb early", 32'h0, 32'(pfd_dn));
            vco_pulse(1);
            chk("fb due", 32'h1, 32'(pfd_dn));
            chk("fb up", 32'h0, 32'(pfd_up));
        end
        $display("test feedback done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
